/* File: bench/fmtsc_checker.sv */
// checker: pin-level assertions of the flip motor controller
`timescale 1ns/1ps
`default_nettype none
module fmtsc_checker #(
   parameter logic [31:0] JAM_CHECK_CYC = 32'h14,
   parameter logic [31:0] END_ARM_CYC   = 32'h28
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // command, bridge and limits
   input wire logic cmd_i,
   input wire logic bridge_cw_o,
   input wire logic bridge_ccw_o,
   input wire logic fwd_limit_o,
   input wire logic rev_limit_o
);
   logic [31:0] on_cnt;
   logic        drv;
   assign drv = bridge_cw_o | bridge_ccw_o;
   // move length seen at the pins, so timing checks need no view inside
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         on_cnt <= 32'h0;
      else
         on_cnt <= drv ? on_cnt + 32'h1 : 32'h0;
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence ccw_end_s;
      $fell(bridge_ccw_o);
   endsequence
   sequence cw_end_s;
      $fell(bridge_cw_o);
   endsequence
   bridge_excl_a: assert property (!(bridge_cw_o && bridge_ccw_o))
      else $error("both legs on");
   cw_cmd_a: assert property ($rose(bridge_cw_o) |-> $past(cmd_i))
      else $error("cw without high command");
   ccw_cmd_a: assert property ($rose(bridge_ccw_o) |-> !$past(cmd_i))
      else $error("ccw without low command");
   jam_time_a: assert property ($rose(fwd_limit_o && rev_limit_o)
      |-> on_cnt == JAM_CHECK_CYC + 32'h1) else $error("jam at wrong time");
   done_time_a: assert property ($fell(drv) && (fwd_limit_o ^ rev_limit_o)
      |-> on_cnt > END_ARM_CYC) else $error("end stop taken too early");
   cw_end_a: assert property (cw_end_s |-> !(!fwd_limit_o && rev_limit_o))
      else $error("cw move ended reverse");
   ccw_end_a: assert property (ccw_end_s |-> !(fwd_limit_o && !rev_limit_o))
      else $error("ccw move ended forward");
   hold_ccw_a: assert property (ccw_end_s ##0 !cmd_i [*5] |-> !drv)
      else $error("no hold after ccw move");
   restart_cw_a: assert property ($rose(cmd_i) && !drv |-> ##[1:3] bridge_cw_o)
      else $error("no restart on command change");
endmodule : fmtsc_checker
`default_nettype wire
bind fmtsc_top fmtsc_checker #(.JAM_CHECK_CYC(JAM_CHECK_CYC), .END_ARM_CYC(END_ARM_CYC)) chk_u (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i), .bridge_cw_o(bridge_cw_o),
   .bridge_ccw_o(bridge_ccw_o), .fwd_limit_o(fwd_limit_o), .rev_limit_o(rev_limit_o));

/* File: bench/fmtsc_motor_model.sv */
// model: motor current as a function of bridge drive and fault mode
`timescale 1ns/1ps
`default_nettype none
module fmtsc_motor_model (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // bridge legs and fault mode: 0 normal, 1 jam, 2 unplugged, 3 loose
   input wire logic        bridge_cw_i,
   input wire logic        bridge_ccw_i,
   input wire logic [1:0]  mode_i,
   // current sample
   output logic [7:0]      cur_o
);
   logic [7:0] mcnt;
   // unpowered motor draws nothing, so no stale value survives a stop
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
      begin
         mcnt <= 8'h0;
         cur_o <= 8'h0;
      end
      else
      begin
         mcnt <= (bridge_cw_i | bridge_ccw_i) ? mcnt + 8'h1 : 8'h0;
         if (!(bridge_cw_i | bridge_ccw_i))
            cur_o <= 8'h0;
         else if (mode_i == 2'h2)
            cur_o <= 8'h08;
         else if (mode_i == 2'h1 || mcnt < 8'h4 || (mode_i == 2'h0 && mcnt > 8'h2C))
            cur_o <= 8'hF0;
         else
            cur_o <= 8'h40;
      end
endmodule : fmtsc_motor_model
`default_nettype wire

/* File: bench/tb.sv */
// testbench: corner and random moves of the flip motor controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int JAM = 20;
   localparam int MAXMV = 80;
   // the model's end-stop spike reaches the sample in move cycle 46, so the drive is on 47 cycles
   localparam int DONE = 47;
   localparam logic [7:0] RA [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h1C};
   localparam logic [31:0] RV [5] = '{32'h1, 32'hFF, 32'h10, 32'h0, 32'h0};
   logic        clk_i, reset_n_i, cmd_i, reg_wr_i, reg_rd_i;
   logic        bridge_cw_o, bridge_ccw_o, fwd_limit_o, rev_limit_o, irq_o;
   logic [7:0]  cur_i, reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, seed;
   logic [1:0]  mode;
   logic [31:0] on_len;
   int          errors, compares;
   logic        n_clr;
   fmtsc_top #(.JAM_CHECK_CYC(32'(JAM)), .END_ARM_CYC(32'h28)) dut_u (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i), .cur_i(cur_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bridge_cw_o(bridge_cw_o),
      .bridge_ccw_o(bridge_ccw_o), .fwd_limit_o(fwd_limit_o), .rev_limit_o(rev_limit_o),
      .irq_o(irq_o));
   fmtsc_motor_model mot_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .bridge_cw_i(bridge_cw_o),
      .bridge_ccw_i(bridge_ccw_o), .mode_i(mode), .cur_o(cur_i));
   // drive time counted at the pins, so the move out of reset is measured in full as well
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i)
         on_len <= 32'h0;
      else if (bridge_cw_o | bridge_ccw_o)
         on_len <= on_len + 32'h1;
      else if (cmd_i != bridge_cw_o && (fwd_limit_o | rev_limit_o | !cmd_i | cmd_i) && 1'b0)
         on_len <= 32'h0;
      else if (!(bridge_cw_o | bridge_ccw_o) && n_clr)
         on_len <= 32'h0;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [1:0] exp_lim(input logic [1:0] m, input logic c);
      return (m == 2'h0) ? {c, !c} : (m == 2'h1) ? 2'h3 : 2'h0;
   endfunction : exp_lim
   task automatic test_done();
      if (errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask : rd
   task automatic move(input logic c, input logic [1:0] m, input logic [3:0] k);
      int n;
      logic [31:0] d;
      wr(8'h14, {28'h0, k});
      cmd_i <= c;
      mode <= m;
      for (n = 0; !(bridge_cw_o | bridge_ccw_o) && n < 9; n++)
         @(posedge clk_i) #1;
      chk("cw leg", bridge_cw_o, c);
      chk("ccw leg", bridge_ccw_o, !c);
      for (n = 0; (bridge_cw_o | bridge_ccw_o) && n < 300; n++)
         @(posedge clk_i) #1;
      chk("length", on_len, (m == 2'h3) ? MAXMV + 1 : (m == 2'h0) ? DONE : JAM + 1);
      n_clr <= 1'b1;
      chk("limits", {fwd_limit_o, rev_limit_o}, exp_lim(m, c));
      chk("irq", irq_o, |((4'h1 << m) & k));
      rd(8'h10, d);
      chk("status", d, 32'h1 << m);
      repeat (5) @(posedge clk_i);
      #1;
      chk("hold", {bridge_cw_o, bridge_ccw_o, fwd_limit_o, rev_limit_o}, exp_lim(m, c));
      n_clr <= 1'b0;
      wr(8'h10, 32'hF);
      rd(8'h10, d);
      chk("clear", {d[30:0], irq_o}, 32'h0);
   endtask : move
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // about 13 moves of at most 120 cycles each; a hang ends far sooner than this
   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      test_done();
   end
   initial
   begin
      logic [31:0] d;
      {errors, compares} = '0;
      {reset_n_i, cmd_i, reg_wr_i, reg_rd_i, mode, reg_addr_i, reg_wdata_i} = '0;
      n_clr = 1'b0;
      seed = 32'h5F16;
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         rd(RA[i], d);
         chk("reset value", d, RV[i]);
      end
      wr(8'h0C, 32'(MAXMV));
      // first move is the one started out of reset; then each mode both ways, then random
      for (int i = 0; i < 13; i++)
      begin
         seed = lfsr(seed);
         move(i[0], (i == 0) ? 2'h0 : (i < 9) ? 2'((i - 1) / 2) : seed[1:0], seed[7:4]);
      end
      test_done();
   end
endmodule : tb
`default_nettype wire

/* File: rtl/fmtsc_pkg.sv */
// package: register map, reset values, timing constants and types of the flip motor controller
package fmtsc_pkg;

   // clock and sequence times
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned JAM_CHECK_MS   = 500;
   localparam int unsigned END_ARM_MS     = 1000;
   localparam int unsigned MAX_MOVE_MS    = 2000;
   localparam logic [31:0] JAM_CHECK_CYC  = 32'(JAM_CHECK_MS * 1000 * CLK_MHZ);
   localparam logic [31:0] END_ARM_CYC    = 32'(END_ARM_MS * 1000 * CLK_MHZ);
   localparam logic [31:0] MAX_MOVE_CYC   = 32'(MAX_MOVE_MS * 1000 * CLK_MHZ);

   // current thresholds in percent of the full-scale reference
   localparam logic [7:0]  JAM_PCT        = 8'h46;
   localparam logic [7:0]  END_PCT        = 8'h4B;
   localparam logic [15:0] PCT_FULL       = 16'h0064;

   // register byte offsets
   localparam logic [7:0]  CTRL_OFS       = 8'h00;
   localparam logic [7:0]  REF_OFS        = 8'h04;
   localparam logic [7:0]  START_THR_OFS  = 8'h08;
   localparam logic [7:0]  MAX_MOVE_OFS   = 8'h0C;
   localparam logic [7:0]  STATUS_OFS     = 8'h10;
   localparam logic [7:0]  MASK_OFS       = 8'h14;
   localparam logic [7:0]  STATE_OFS      = 8'h18;

   // register reset values
   localparam logic        CTRL_EN_RST    = 1'b1;
   localparam logic [7:0]  REF_RST        = 8'hFF;
   localparam logic [7:0]  START_THR_RST  = 8'h10;
   localparam logic [3:0]  MASK_RST       = 4'h0;

   // status and mask bit positions
   localparam int unsigned EV_DONE        = 0;
   localparam int unsigned EV_JAM         = 1;
   localparam int unsigned EV_NOMOTOR     = 2;
   localparam int unsigned EV_RUNAWAY     = 3;
   localparam int unsigned EV_N           = 4;

   typedef enum logic [1:0] {
      FMTSC_IDLE,
      FMTSC_RUN,
      FMTSC_HOLD
   } fmtsc_fsm_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fmtsc_bus_s;

   typedef struct packed {
      fmtsc_fsm_e  fsm;
      logic        dir;
      logic [31:0] cnt;
      logic        seen_start;
      logic        bridge_cw;
      logic        bridge_ccw;
      logic        fwd_limit;
      logic        rev_limit;
      logic        irq;
      logic [31:0] rd_data;
      logic        ctrl_en;
      logic [7:0]  ref_full;
      logic [7:0]  start_thr;
      logic [31:0] max_move;
      logic [3:0]  status;
      logic [3:0]  mask;
   } fmtsc_state_s;

endpackage : fmtsc_pkg

/* File: rtl/fmtsc_top.sv */
// module: two-position flip motor controller with current sensing and register port
// Behaviour
// - a high host command drives the bridge so the motor turns clockwise.
// - a low host command drives the bridge so the motor turns counterclockwise.
// - if current never exceeds the start threshold after motion starts, both limits go to 0.
// - half a second into the move the current must be below 70% of reference, else a jam.
// - on a jam both forward and reverse limits go to 1.
// - after one second, current rising to 75% of reference marks the end stop and stops the drive.
// - a finished counterclockwise move sets forward limit 0 and reverse limit 1.
// - a finished clockwise move sets forward limit 1 and reverse limit 0.
// - after a counterclockwise sequence ends, hold while the command stays low, restart on change.
// - after a clockwise sequence ends, hold while the command stays high, restart on change.
// - current that stays steady and never reaches the end-stop level is a run-away.
`timescale 1ns/1ps
`default_nettype none

module fmtsc_top #(
   parameter logic [31:0] JAM_CHECK_CYC = fmtsc_pkg::JAM_CHECK_CYC,
   parameter logic [31:0] END_ARM_CYC   = fmtsc_pkg::END_ARM_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // host control module command and current sample
   input  wire logic        cmd_i,
   input  wire logic [7:0]  cur_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   // motor bridge
   output logic             bridge_cw_o,
   output logic             bridge_ccw_o,
   // limit status back to the host control module
   output logic             fwd_limit_o,
   output logic             rev_limit_o,
   // interrupt
   output logic             irq_o
);

   fmtsc_pkg::fmtsc_state_s s;
   fmtsc_pkg::fmtsc_state_s next_s;
   fmtsc_pkg::fmtsc_bus_s   bus;

   assign bus.addr  = reg_addr_i;
   assign bus.wdata = reg_wdata_i;
   assign bus.wr    = reg_wr_i;
   assign bus.rd    = reg_rd_i;

   // true while sample is below pct percent of full scale; cross-multiplied to avoid a divider
   function automatic logic below_pct(input logic [7:0] smp,
                                      input logic [7:0] full,
                                      input logic [7:0] pct);
      logic [15:0] lhs;
      logic [15:0] rhs;
      lhs = {8'h00, smp} * fmtsc_pkg::PCT_FULL;
      rhs = {8'h00, full} * {8'h00, pct};
      return lhs < rhs;
   endfunction : below_pct

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction : hit

   always_comb
   begin
      logic       started;
      logic [3:0] ev;
      logic [3:0] clr;
      started = 1'b0;
      ev      = 4'h0;
      clr     = 4'h0;
      next_s  = s;
      next_s.rd_data = 32'h0000_0000;

      // register writes
      if (bus.wr)
      begin
         if (hit(bus.addr, fmtsc_pkg::CTRL_OFS))
         begin
            next_s.ctrl_en = bus.wdata[0];
         end
         else if (hit(bus.addr, fmtsc_pkg::REF_OFS))
         begin
            next_s.ref_full = bus.wdata[7:0];
         end
         else if (hit(bus.addr, fmtsc_pkg::START_THR_OFS))
         begin
            next_s.start_thr = bus.wdata[7:0];
         end
         else if (hit(bus.addr, fmtsc_pkg::MAX_MOVE_OFS))
         begin
            next_s.max_move = bus.wdata;
         end
         else if (hit(bus.addr, fmtsc_pkg::STATUS_OFS))
         begin
            clr = bus.wdata[3:0];
         end
         else if (hit(bus.addr, fmtsc_pkg::MASK_OFS))
         begin
            next_s.mask = bus.wdata[3:0];
         end
      end

      // register reads; unmapped addresses read zero
      if (bus.rd)
      begin
         if (hit(bus.addr, fmtsc_pkg::CTRL_OFS))
         begin
            next_s.rd_data = {31'h0000_0000, s.ctrl_en};
         end
         else if (hit(bus.addr, fmtsc_pkg::REF_OFS))
         begin
            next_s.rd_data = {24'h00_0000, s.ref_full};
         end
         else if (hit(bus.addr, fmtsc_pkg::START_THR_OFS))
         begin
            next_s.rd_data = {24'h00_0000, s.start_thr};
         end
         else if (hit(bus.addr, fmtsc_pkg::MAX_MOVE_OFS))
         begin
            next_s.rd_data = s.max_move;
         end
         else if (hit(bus.addr, fmtsc_pkg::STATUS_OFS))
         begin
            next_s.rd_data = {28'h000_0000, s.status};
         end
         else if (hit(bus.addr, fmtsc_pkg::MASK_OFS))
         begin
            next_s.rd_data = {28'h000_0000, s.mask};
         end
         else if (hit(bus.addr, fmtsc_pkg::STATE_OFS))
         begin
            next_s.rd_data = {24'h00_0000, s.fwd_limit, s.rev_limit, s.bridge_cw,
                              s.bridge_ccw, s.seen_start, s.dir, 2'(s.fsm)};
         end
      end

      // move sequencer
      case (s.fsm)
         fmtsc_pkg::FMTSC_IDLE:
         begin
            next_s.bridge_cw  = 1'b0;
            next_s.bridge_ccw = 1'b0;
            if (s.ctrl_en)
            begin
               next_s.dir        = cmd_i;
               next_s.cnt        = 32'h0000_0000;
               next_s.seen_start = 1'b0;
               next_s.fwd_limit  = 1'b0;
               next_s.rev_limit  = 1'b0;
               next_s.bridge_cw  = cmd_i;
               next_s.bridge_ccw = !cmd_i;
               next_s.fsm        = fmtsc_pkg::FMTSC_RUN;
            end
         end
         fmtsc_pkg::FMTSC_RUN:
         begin
            next_s.cnt = s.cnt + 32'h0000_0001;
            started    = s.seen_start || (cur_i > s.start_thr);
            next_s.seen_start = started;
            if (!s.ctrl_en)
            begin
               // software abort: drive off, sequence restarts once enabled again
               next_s.bridge_cw  = 1'b0;
               next_s.bridge_ccw = 1'b0;
               next_s.fsm        = fmtsc_pkg::FMTSC_IDLE;
            end
            else if (s.cnt == JAM_CHECK_CYC && !started)
            begin
               next_s.fwd_limit  = 1'b0;
               next_s.rev_limit  = 1'b0;
               next_s.bridge_cw  = 1'b0;
               next_s.bridge_ccw = 1'b0;
               ev[fmtsc_pkg::EV_NOMOTOR] = 1'b1;
               next_s.fsm        = fmtsc_pkg::FMTSC_HOLD;
            end
            else if (s.cnt == JAM_CHECK_CYC &&
                     !below_pct(cur_i, s.ref_full, fmtsc_pkg::JAM_PCT))
            begin
               next_s.fwd_limit  = 1'b1;
               next_s.rev_limit  = 1'b1;
               next_s.bridge_cw  = 1'b0;
               next_s.bridge_ccw = 1'b0;
               ev[fmtsc_pkg::EV_JAM] = 1'b1;
               next_s.fsm        = fmtsc_pkg::FMTSC_HOLD;
            end
            else if (s.cnt >= END_ARM_CYC &&
                     !below_pct(cur_i, s.ref_full, fmtsc_pkg::END_PCT))
            begin
               next_s.bridge_cw  = 1'b0;
               next_s.bridge_ccw = 1'b0;
               next_s.fwd_limit  = s.dir;
               next_s.rev_limit  = !s.dir;
               ev[fmtsc_pkg::EV_DONE] = 1'b1;
               next_s.fsm        = fmtsc_pkg::FMTSC_HOLD;
            end
            else if (s.cnt >= s.max_move)
            begin
               // steady current with no end stop: shaft has lost its load
               next_s.bridge_cw  = 1'b0;
               next_s.bridge_ccw = 1'b0;
               ev[fmtsc_pkg::EV_RUNAWAY] = 1'b1;
               next_s.fsm        = fmtsc_pkg::FMTSC_HOLD;
            end
         end
         fmtsc_pkg::FMTSC_HOLD:
         begin
            next_s.bridge_cw  = 1'b0;
            next_s.bridge_ccw = 1'b0;
            // command changes only matter here; a mid-move change waits for the move to end
            if (cmd_i != s.dir)
            begin
               next_s.fsm = fmtsc_pkg::FMTSC_IDLE;
            end
         end
         default:
         begin
            next_s.fsm = fmtsc_pkg::FMTSC_IDLE;
         end
      endcase

      // sticky status: a new event wins over a clear in the same cycle
      next_s.status = (s.status & ~clr) | ev;
      next_s.irq    = |(next_s.status & next_s.mask);
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s            <= '0;
         s.fsm        <= fmtsc_pkg::FMTSC_IDLE;
         s.ctrl_en    <= fmtsc_pkg::CTRL_EN_RST;
         s.ref_full   <= fmtsc_pkg::REF_RST;
         s.start_thr  <= fmtsc_pkg::START_THR_RST;
         s.max_move   <= fmtsc_pkg::MAX_MOVE_CYC;
         s.mask       <= fmtsc_pkg::MASK_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign reg_rdata_o  = s.rd_data;
   assign bridge_cw_o  = s.bridge_cw;
   assign bridge_ccw_o = s.bridge_ccw;
   assign fwd_limit_o  = s.fwd_limit;
   assign rev_limit_o  = s.rev_limit;
   assign irq_o        = s.irq;

endmodule : fmtsc_top

`default_nettype wire
